// ===== pkg/vbpc_regs.vh
// register offsets, field positions, reset values and timing constants of the vbus boost block
`ifndef VBPC_REGS_VH
`define VBPC_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define VBPC_USB_POWER_CONTROL_OFS 8'h00
`define VBPC_OTG_CONTROL_OFS       8'h04
`define VBPC_BOOST_PWM_RATE_OFS    8'h08
`define VBPC_BOOST_PWM_CONTROL_OFS 8'h0c
`define VBPC_XCVR_CONTROL_OFS      8'h10
`define VBPC_STATUS_OFS            8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VBPC_PWR_MODULE_ON_BIT     0
`define VBPC_OTG_DISCHARGE_BIT     0
`define VBPC_OTG_TARGET_SEL_BIT    1
`define VBPC_OTG_GEN_ENABLE_BIT    3
`define VBPC_RATE_PERIOD_LSB       0
`define VBPC_RATE_DUTY_LSB         8
`define VBPC_PWM_POLARITY_BIT      9
`define VBPC_PWM_COUNTER_EN_BIT    8
`define VBPC_PWM_UNIT_EN_BIT       15
`define VBPC_XCVR_DP_PULLUP_BIT    0
`define VBPC_XCVR_DM_PULLUP_BIT    1
`define VBPC_XCVR_DP_PULLDOWN_BIT  2
`define VBPC_XCVR_DM_PULLDOWN_BIT  3
`define VBPC_XCVR_EXT_GEN_BIT      4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VBPC_RESET_WORD16          16'h0000
`define VBPC_RESET_BYTE            8'h00

// ----------------------------------------------------------------
// timing: comparator filter count limit; a level must hold one clock longer than this to pass
// ----------------------------------------------------------------
`define VBPC_CMP_FILTER_CYCLES     4'h3

// axi responses
`define VBPC_RESP_OKAY             2'b00
`define VBPC_RESP_SLVERR           2'b10

`endif

// ===== verilog/vbpc_pwm_core.v
// pwm counter and compare stage of the vbus boost assist
`timescale 1ns/1ps
module vbpc_pwm_core (
  // clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // control
  input  wire [7:0] period,
  input  wire [7:0] duty,
  input  wire       polarity,
  input  wire       counterEn,
  input  wire       unitEn,
  input  wire       holdOff,
  // output
  output reg        pwmOut,
  output wire [7:0] count
);

  reg  [7:0] count_q;
  reg  [7:0] count_d;
  wire       active;

  assign count = count_q;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always @* begin
    count_d = count_q;
    if (counterEn) begin
      if (count_q >= period)
        count_d = 8'h00;
      else
        count_d = count_q + 8'h01;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      count_q <= 8'h00;
    else
      count_q <= count_d;
  end

  // ----------------------------------------------------------------
  // compare and polarity
  // ----------------------------------------------------------------
  // comparator hold-off forces the switch to its idle level
  assign active = (count_q < duty) & ~holdOff;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      pwmOut <= 1'b0;
    else if (!unitEn)
      pwmOut <= 1'b0;
    else
      pwmOut <= active ^ polarity;
  end

endmodule // vbpc_pwm_core

// ===== verilog/vbpc_cmp_filter.v
// glitch filter for one comparator level input
`timescale 1ns/1ps
`include "vbpc_regs.vh"
module vbpc_cmp_filter (
  // clock and reset
  input  wire mclk,
  input  wire rst_n,
  // level
  input  wire rawIn,
  output reg  filtered
);

  reg [3:0] cnt_q;

  // output follows input only after it has held for the filter length
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= 4'h0;
      filtered <= 1'b0;
    end else if (rawIn == filtered) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= `VBPC_CMP_FILTER_CYCLES) begin
      cnt_q    <= 4'h0;
      filtered <= rawIn;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

endmodule // vbpc_cmp_filter

// ===== verilog/vbpc_vbus_boost.v
// vbus boost pwm control block with axi4-lite register slave
`timescale 1ns/1ps
`include "vbpc_regs.vh"

module vbpc_vbus_boost (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // boost supply
  output reg         boostPwm,
  output reg         boostPwmOe_n,
  output reg         busTargetHigh,
  output reg         busGenOn,
  output reg         busDischarge,
  // comparators
  input  wire        vbusAboveTarget,
  input  wire        overCurrent,
  // external transceiver
  output reg         dpPullup,
  output reg         dmPullup,
  output reg         dpPulldown,
  output reg         dmPulldown,
  output reg         extGenEnable
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [15:0] pwrCtrl_q;
  reg  [15:0] otgCtrl_q;
  reg  [15:0] pwmRate_q;
  reg  [15:0] pwmCtrl_q;
  reg  [15:0] xcvrCtrl_q;
  reg  [7:0]  awAddr_q;
  reg         awHeld_q;
  reg  [31:0] wData_q;
  reg  [3:0]  wStrb_q;
  reg         wHeld_q;
  wire        doWrite;
  wire        doRead;
  wire        cmpHigh;
  wire        cmpOverI;
  wire        pwmRaw;
  wire [7:0]  pwmCount;
  wire        moduleOn;
  wire        genActive;
  wire        onChipBoost;
  reg  [31:0] rdWord;

  // byte-lane merge for a 16-bit register
  function [15:0] mergeLanes;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      mergeLanes[7:0]  = strb[0] ? data[7:0]  : old[7:0];
      mergeLanes[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  // true when an address names a mapped register
  function isMapped;
    input [7:0] addr;
    begin
      case (addr)
        `VBPC_USB_POWER_CONTROL_OFS,
        `VBPC_OTG_CONTROL_OFS,
        `VBPC_BOOST_PWM_RATE_OFS,
        `VBPC_BOOST_PWM_CONTROL_OFS,
        `VBPC_XCVR_CONTROL_OFS,
        `VBPC_STATUS_OFS: isMapped = 1'b1;
        default:          isMapped = 1'b0;
      endcase
    end
  endfunction

  // word-aligned form of a byte address
  function [7:0] wordAddr;
    input [7:0] addr;
    begin
      wordAddr = {addr[7:2], 2'b00};
    end
  endfunction

  // true when software may write the register at an address
  function isWritable;
    input [7:0] addr;
    begin
      isWritable = isMapped(addr) && (addr != `VBPC_STATUS_OFS);
    end
  endfunction

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  // address and data are parked in either order until both are in
  // no new write is taken while a response waits: one write in flight
  assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld_q & ~s_axi_bvalid;
  assign doWrite       = awHeld_q & wHeld_q & ~s_axi_bvalid;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awAddr_q     <= 8'h00;
      awHeld_q     <= 1'b0;
      wData_q      <= 32'h00000000;
      wStrb_q      <= 4'h0;
      wHeld_q      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `VBPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q <= wordAddr(s_axi_awaddr);
        awHeld_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHeld_q <= 1'b1;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isWritable(awAddr_q) ? `VBPC_RESP_OKAY : `VBPC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwrCtrl_q  <= `VBPC_RESET_WORD16;
      otgCtrl_q  <= `VBPC_RESET_WORD16;
      pwmRate_q  <= `VBPC_RESET_WORD16;
      pwmCtrl_q  <= `VBPC_RESET_WORD16;
      xcvrCtrl_q <= `VBPC_RESET_WORD16;
    end else if (doWrite) begin
      case (awAddr_q)
        `VBPC_USB_POWER_CONTROL_OFS: pwrCtrl_q  <= mergeLanes(pwrCtrl_q, wData_q, wStrb_q);
        `VBPC_OTG_CONTROL_OFS:       otgCtrl_q  <= mergeLanes(otgCtrl_q, wData_q, wStrb_q);
        `VBPC_BOOST_PWM_RATE_OFS:    pwmRate_q  <= mergeLanes(pwmRate_q, wData_q, wStrb_q);
        `VBPC_BOOST_PWM_CONTROL_OFS: pwmCtrl_q  <= mergeLanes(pwmCtrl_q, wData_q, wStrb_q);
        `VBPC_XCVR_CONTROL_OFS:      xcvrCtrl_q <= mergeLanes(xcvrCtrl_q, wData_q, wStrb_q);
        // status and unmapped offsets were answered with an error: nothing changes
        default:                     pwrCtrl_q  <= pwrCtrl_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign doRead        = s_axi_arvalid & s_axi_arready;

  // ----------------------------------------------------------------
  // read data select
  // ----------------------------------------------------------------
  // status word is live: it shows comparators and counter as they stand
  always @* begin
    case (wordAddr(s_axi_araddr))
      `VBPC_USB_POWER_CONTROL_OFS: rdWord = {16'h0000, pwrCtrl_q};
      `VBPC_OTG_CONTROL_OFS:       rdWord = {16'h0000, otgCtrl_q};
      `VBPC_BOOST_PWM_RATE_OFS:    rdWord = {16'h0000, pwmRate_q};
      `VBPC_BOOST_PWM_CONTROL_OFS: rdWord = {16'h0000, pwmCtrl_q};
      `VBPC_XCVR_CONTROL_OFS:      rdWord = {16'h0000, xcvrCtrl_q};
      `VBPC_STATUS_OFS:            rdWord = {20'h00000, cmpOverI, cmpHigh,
                                             genActive, boostPwm, pwmCount};
      default:                     rdWord = 32'h00000000;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `VBPC_RESP_OKAY;
    end else if (doRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= isMapped(wordAddr(s_axi_araddr)) ?
                      `VBPC_RESP_OKAY : `VBPC_RESP_SLVERR;
      s_axi_rdata  <= rdWord;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  vbpc_cmp_filter uVoltCmp (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .rawIn    (vbusAboveTarget),
    .filtered (cmpHigh)
  );

  vbpc_cmp_filter uCurrCmp (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .rawIn    (overCurrent),
    .filtered (cmpOverI)
  );

  // ----------------------------------------------------------------
  // pwm generation
  // ----------------------------------------------------------------
  assign moduleOn    = pwrCtrl_q[`VBPC_PWR_MODULE_ON_BIT];
  // generation needs module power and no discharge
  assign genActive   = otgCtrl_q[`VBPC_OTG_GEN_ENABLE_BIT] & moduleOn &
                       ~otgCtrl_q[`VBPC_OTG_DISCHARGE_BIT];
  // external topology takes over from the on-chip boost
  assign onChipBoost = ~xcvrCtrl_q[`VBPC_XCVR_EXT_GEN_BIT];

  vbpc_pwm_core uPwm (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .period    (pwmRate_q[`VBPC_RATE_PERIOD_LSB +: 8]),
    .duty      (pwmRate_q[`VBPC_RATE_DUTY_LSB +: 8]),
    .polarity  (pwmCtrl_q[`VBPC_PWM_POLARITY_BIT]),
    .counterEn (pwmCtrl_q[`VBPC_PWM_COUNTER_EN_BIT]),
    .unitEn    (pwmCtrl_q[`VBPC_PWM_UNIT_EN_BIT] & genActive & onChipBoost),
    .holdOff   (cmpHigh | cmpOverI),
    .pwmOut    (pwmRaw),
    .count     (pwmCount)
  );

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boostPwm      <= 1'b0;
      boostPwmOe_n  <= 1'b1;
      busTargetHigh <= 1'b0;
      busGenOn      <= 1'b0;
      busDischarge  <= 1'b0;
      extGenEnable  <= 1'b0;
    end else begin
      boostPwm      <= pwmRaw;
      boostPwmOe_n  <= ~(pwmCtrl_q[`VBPC_PWM_UNIT_EN_BIT] & onChipBoost);
      busTargetHigh <= otgCtrl_q[`VBPC_OTG_TARGET_SEL_BIT];
      busGenOn      <= genActive;
      busDischarge  <= otgCtrl_q[`VBPC_OTG_DISCHARGE_BIT];
      extGenEnable  <= genActive & ~onChipBoost;
    end
  end

  // ----------------------------------------------------------------
  // transceiver control pins
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dpPullup      <= 1'b0;
      dmPullup      <= 1'b0;
      dpPulldown    <= 1'b0;
      dmPulldown    <= 1'b0;
    end else begin
      dpPullup      <= xcvrCtrl_q[`VBPC_XCVR_DP_PULLUP_BIT];
      dmPullup      <= xcvrCtrl_q[`VBPC_XCVR_DM_PULLUP_BIT];
      dpPulldown    <= xcvrCtrl_q[`VBPC_XCVR_DP_PULLDOWN_BIT];
      dmPulldown    <= xcvrCtrl_q[`VBPC_XCVR_DM_PULLDOWN_BIT];
    end
  end

endmodule // vbpc_vbus_boost

// ===== dv/vbpc_vbus_boost_sva.sv
// assertion checker on the ports of the vbus boost block
`timescale 1ns/1ps
module vbpc_vbus_boost_sva (
  // clock and reset
  input wire        mclk,
  input wire        rst_n,
  // register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // supply side
  input wire        boostPwm,
  input wire        boostPwmOe_n,
  input wire        busGenOn,
  input wire        extGenEnable,
  input wire        overCurrent
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  read_answer_a: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (wrTaken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing wrong");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  unmapped_read_a: assert property (rdTaken and s_axi_araddr[7:2] > 6'h05 |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  ext_gen_a: assert property (extGenEnable |-> busGenOn)
    else $error("external generation without generation");
  pwm_quiet_a: assert property (boostPwmOe_n [*4] |-> !boostPwm)
    else $error("pulse output while unit off");
  current_limit_a: assert property (overCurrent [*8] ##1 overCurrent |-> $stable(boostPwm))
    else $error("switching during current limit");
endmodule // vbpc_vbus_boost_sva

bind vbpc_vbus_boost vbpc_vbus_boost_sva u_sva (
  .mclk(mclk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .boostPwm(boostPwm), .boostPwmOe_n(boostPwmOe_n), .busGenOn(busGenOn),
  .extGenEnable(extGenEnable), .overCurrent(overCurrent)
);

// ===== dv/vbpc_supply_model.sv
// behavioural switch-mode supply on the vbus rail
`timescale 1ns/1ps
module vbpc_supply_model (
  // clock and reset
  input  wire mclk,
  input  wire rst_n,
  // from the boost block
  input  wire boostPwm,
  input  wire boostPwmOe_n,
  input  wire busGenOn,
  input  wire busTargetHigh,
  // bench command
  input  wire loadFault,
  // comparator levels
  output wire vbusAboveTarget,
  output wire overCurrent
);
  reg [7:0] railLevel_q;
  // rail charges one step per driven pulse cycle, collapses with generation off
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      railLevel_q <= 8'h00;
    else if (!busGenOn)
      railLevel_q <= 8'h00;
    else if (boostPwm && !boostPwmOe_n && railLevel_q != 8'hff)
      railLevel_q <= railLevel_q + 8'h01;
  end
  assign vbusAboveTarget = railLevel_q >= (busTargetHigh ? 8'hc8 : 8'h96);
  assign overCurrent = loadFault;
endmodule // vbpc_supply_model

// ===== dv/test_vbus_boost_pwm_control.sv
// self-checking bench for the vbus boost block
`timescale 1ns/1ps
`include "vbpc_regs.vh"
module test_vbus_boost_pwm_control;
  localparam [7:0] PWR = `VBPC_USB_POWER_CONTROL_OFS;
  localparam [7:0] OTG = `VBPC_OTG_CONTROL_OFS;
  localparam [7:0] RATE = `VBPC_BOOST_PWM_RATE_OFS;
  localparam [7:0] CTL = `VBPC_BOOST_PWM_CONTROL_OFS;
  localparam [7:0] XCVR = `VBPC_XCVR_CONTROL_OFS;
  localparam [7:0] ST = `VBPC_STATUS_OFS;
  localparam [1:0] OK = `VBPC_RESP_OKAY;
  localparam [1:0] ERR = `VBPC_RESP_SLVERR;
  logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, loadFault;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd, c;
  logic [3:0]  wstrb;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         boostPwm, pwmOe_n, tgtHigh, genOn, dischg, aboveTgt, overCur;
  wire  [4:0]  xcvr;
  int          errors, num_checks, n;

  vbpc_vbus_boost DUT (
    .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .boostPwm(boostPwm), .boostPwmOe_n(pwmOe_n), .busTargetHigh(tgtHigh), .busGenOn(genOn),
    .busDischarge(dischg), .vbusAboveTarget(aboveTgt), .overCurrent(overCur),
    .dpPullup(xcvr[0]), .dmPullup(xcvr[1]), .dpPulldown(xcvr[2]), .dmPulldown(xcvr[3]),
    .extGenEnable(xcvr[4])
  );
  vbpc_supply_model supply (
    .mclk(mclk), .rst_n(rst_n), .boostPwm(boostPwm), .boostPwmOe_n(pwmOe_n),
    .busGenOn(genOn), .busTargetHigh(tgtHigh), .loadFault(loadFault),
    .vbusAboveTarget(aboveTgt), .overCurrent(overCur)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task axiWrite(input [7:0] a, input [15:0] d, input [3:0] s, input [1:0] er);
    bit awOk, wOk;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awOk = 0;
    wOk = 0;
    while (!(awOk && wOk)) begin
      @(negedge mclk);
      awOk = awOk || awready;
      wOk = wOk || wready;
      @(posedge mclk);
      if (awOk) awvalid <= 1'b0;
      if (wOk) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do @(negedge mclk); while (bvalid !== 1'b1);
    check(bresp, er, "write response");
    @(posedge mclk);
    bready <= 1'b0;
  endtask

  task axiRead(input [7:0] a, input [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge mclk); while (arready !== 1'b1);
    @(posedge mclk);
    arvalid <= 1'b0;
    do @(negedge mclk); while (rvalid !== 1'b1);
    rd = rdata;
    check(rresp, er, "read response");
    @(posedge mclk);
    rready <= 1'b0;
  endtask

  task rdChk(input [7:0] a, input [31:0] e, input string what);
    axiRead(a, OK);
    check(rd, e, what);
  endtask

  task idle(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // high cycles of the pulse output over ten periods of four steps
  task pwmHigh();
    idle(4);
    n = 0;
    repeat (40) begin
      @(negedge mclk);
      n += (boostPwm === 1'b1);
    end
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, loadFault} = 6'h00;
    {awaddr, araddr, wstrb, wdata} = 52'h0;
    errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    idle(2);
    check({pwmOe_n, boostPwm, genOn, tgtHigh, dischg, xcvr}, 10'h200, "reset outputs");
    for (int i = 0; i < 6; i++) rdChk(8'(i * 4), 32'h0, "reset value");
    axiRead(8'h18, ERR);
    check(rd, 32'h0, "unmapped data");
    axiWrite(8'h18, 16'hffff, 4'h3, ERR);
    axiWrite(ST, 16'h0001, 4'h3, ERR);
    $display("test reset and map done");
    axiWrite(RATE, 16'hc3a5, 4'h3, OK);
    rdChk(RATE, 32'hc3a5, "rate word");
    axiWrite(RATE, 16'h5a5a, 4'h1, OK);
    rdChk(RATE, 32'hc35a, "rate low lane");
    for (int i = 0; i < 4; i++) begin
      axiWrite(XCVR, 16'(1 << i), 4'h3, OK);
      idle(2);
      check(xcvr, 32'(1 << i), "transceiver control");
    end
    axiWrite(XCVR, 16'h0000, 4'h3, OK);
    axiWrite(OTG, 16'h0003, 4'h3, OK);
    idle(2);
    check({tgtHigh, dischg}, 2'h3, "target and discharge");
    $display("test fields done");
    axiWrite(OTG, 16'h0000, 4'h3, OK);
    axiWrite(PWR, 16'h0001, 4'h3, OK);
    rdChk(OTG, 32'h0, "discharge off");
    axiWrite(RATE, 16'h0103, 4'h3, OK);
    axiWrite(CTL, 16'h0000, 4'h3, OK);
    axiWrite(OTG, 16'h0002, 4'h3, OK);
    axiWrite(CTL, 16'h0100, 4'h3, OK);
    axiWrite(CTL, 16'h8100, 4'h3, OK);
    axiWrite(OTG, 16'h000a, 4'h3, OK);
    idle(2);
    check({genOn, pwmOe_n}, 2'h2, "generation on");
    pwmHigh();
    check(n, 10, "duty one of four");
    axiWrite(CTL, 16'h8300, 4'h3, OK);
    pwmHigh();
    check(n, 30, "inverted polarity");
    axiWrite(CTL, 16'h8200, 4'h3, OK);
    axiRead(ST, OK);
    c = rd;
    idle(6);
    rdChk(ST, c, "counter held");
    $display("test enable sequence done");
    axiWrite(CTL, 16'h8100, 4'h3, OK);
    @(posedge mclk);
    loadFault <= 1'b1;
    idle(10);
    pwmHigh();
    check(n, 0, "current limit");
    axiRead(ST, OK);
    check(rd[11], 1'b1, "current flag");
    @(posedge mclk);
    loadFault <= 1'b0;
    axiWrite(OTG, 16'h000b, 4'h3, OK);
    idle(2);
    check(genOn, 1'b0, "discharge blocks generation");
    axiWrite(OTG, 16'h000a, 4'h3, OK);
    axiWrite(XCVR, 16'h0010, 4'h3, OK);
    idle(2);
    check({genOn, xcvr[4], pwmOe_n}, 3'h7, "external topology");
    axiWrite(XCVR, 16'h0000, 4'h3, OK);
    axiWrite(CTL, 16'h0100, 4'h3, OK);
    pwmHigh();
    check({n[5:0], pwmOe_n}, 7'h01, "unit off");
    axiWrite(RATE, 16'h0403, 4'h3, OK);
    axiWrite(OTG, 16'h0008, 4'h3, OK);
    axiWrite(CTL, 16'h8100, 4'h3, OK);
    idle(200);
    axiRead(ST, OK);
    check(rd[10], 1'b1, "voltage flag");
    pwmHigh();
    check(n, 0, "voltage limit");
    $display("test limits and topology done");
    summarize();
  end

  initial begin
    #2000000;
    errors++;
    summarize();
  end
endmodule // test_vbus_boost_pwm_control
